/* rtl/serial_link_pkg.sv */
// Register map, constants and carrier types of the serial link controller
// Functional notes
// (RL1) Characters carry 5 to 8 data bits; other settings are refused.
// (RL2) Each sent character ends with one or two stop bits as set.
// (RL3) A response waits at least the reply hold time before sending.
// (RL4) After raising RTS the first bit waits the RTS lead time.
// (RL5) RTS stays high for the trail time after the last byte.
// (RL6) With CTS gating on, no character starts while CTS is low.
// (RL7) After a DLE-ACK the poll request waits the poll gap time.
// (RL8) The master only runs the first N commands of its list.
// (RL9) First issues are spaced by the command gap; retries are not.
// (RL10) Fault data goes to the fault pointer, none when it is -1.
// (RL11) The master times each reply in ms and resends on timeout.
// (RL12) A failing command is resent up to the retry limit.
// (RL13) A silent node is skipped for the set count of polls.
// (RL14) 256 node status words go to the health pointer unless -1.
// (RL15) The first simulated integer file number is fixed at 7.
// (RL16) Every simulated file is fixed at 200 words.
// (RL17) File element zero maps to word 0, files follow every 200 words.
// (RL18) Parity codes: 0 none, 1 odd, 2 even, 3 mark, 4 space.
// (RL19) Role 0 selects master, role 1 selects slave.
// (RL20) Check mode 0 selects block check char, 1 selects CRC.
// (RL21) All ms waits use one shared 1 ms tick; zero means no wait.
package serial_link_pkg;
	localparam logic [15:0] IDX_DATA_WIDTH  = 16'h1399;
	localparam logic [15:0] IDX_STOP_COUNT  = 16'h139a;
	localparam logic [15:0] IDX_REPLY_HOLD  = 16'h139b;
	localparam logic [15:0] IDX_RTS_LEAD    = 16'h139c;
	localparam logic [15:0] IDX_RTS_TRAIL   = 16'h139d;
	localparam logic [15:0] IDX_CTS_GATE    = 16'h139e;
	localparam logic [15:0] IDX_POLL_GAP    = 16'h139f;
	localparam logic [15:0] IDX_CMD_TOTAL   = 16'h13a0;
	localparam logic [15:0] IDX_CMD_SPACING = 16'h13a1;
	localparam logic [15:0] IDX_FAULT_DEST  = 16'h13a2;
	localparam logic [15:0] IDX_REPLY_WAIT  = 16'h13a3;
	localparam logic [15:0] IDX_RESEND_LIM  = 16'h13a4;
	localparam logic [15:0] IDX_SKIP_POLLS  = 16'h13a5;
	localparam logic [15:0] IDX_HEALTH_DEST = 16'h13a6;
	localparam logic [15:0] IDX_FILE_NUMBER = 16'h13a8;
	localparam logic [15:0] IDX_FILE_LENGTH = 16'h13a9;
	localparam logic [15:0] IDX_FILE_BASE   = 16'h13aa;
	localparam logic [15:0] IDX_PARITY      = 16'h13b0;
	localparam logic [15:0] IDX_ROLE        = 16'h13b1;
	localparam logic [15:0] IDX_CHECK_MODE  = 16'h13b2;
	localparam logic [15:0] IDX_BIT_CYCLES  = 16'h13b3;
	localparam logic [15:0] IDX_CONTROL     = 16'h13b4;
	localparam logic [15:0] IDX_STATUS      = 16'h13b5;
	localparam int          CLK_HZ          = 100000000;
	localparam int          TICK_MS         = 1;
	localparam logic [15:0] PTR_NONE        = 16'hffff;
	localparam logic [15:0] FAULT_DEST_MAX  = 16'h1387;
	localparam logic [15:0] HEALTH_DEST_MAX = 16'h1287;
	localparam logic [15:0] CMD_TOTAL_MAX   = 16'h0064;
	localparam logic [15:0] RESEND_MAX      = 16'h000a;
	localparam logic [15:0] FILE_FIRST      = 16'h0007;
	localparam logic [15:0] FILE_WORDS      = 16'h00c8;
	localparam logic [15:0] FILE_DB_BASE    = 16'h0000;
	localparam logic [3:0]  WIDTH_MIN       = 4'h5;
	localparam logic [3:0]  WIDTH_MAX       = 4'h8;
	localparam logic [2:0]  PAR_NONE        = 3'h0;
	localparam logic [2:0]  PAR_ODD         = 3'h1;
	localparam logic [2:0]  PAR_EVEN        = 3'h2;
	localparam logic [2:0]  PAR_MARK        = 3'h3;
	localparam logic [2:0]  PAR_SPACE       = 3'h4;
	localparam logic        ROLE_MASTER     = 1'b0;
	localparam logic        ROLE_SLAVE      = 1'b1;
	localparam logic        CHECK_CRC       = 1'b1;
	localparam logic [15:0] CRC_POLY        = 16'ha001;
	localparam logic [15:0] BIT_CYCLES_RST  = 16'h0364;
	localparam logic [15:0] BIT_CYCLES_MIN  = 16'h0004;

	typedef enum logic [2:0] {TX_IDLE, TX_HOLD, TX_LEAD, TX_CTS, TX_SHIFT,
		TX_TRAIL} tx_state_type;
	typedef enum logic [2:0] {M_CLEAR, M_IDLE, M_SPACE, M_PICK, M_WAIT,
		M_SWEEP} master_state_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [15:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_type;
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} tx_byte_type;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       parity_err;
		logic       frame_err;
	} rx_byte_type;
	typedef struct packed {
		logic       issue;
		logic       retry;
		logic [6:0] index;
	} cmd_issue_type;
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] data;
	} db_write_type;
	typedef struct packed {
		logic        valid;
		logic [15:0] number;
		logic [15:0] element;
	} file_req_type;
	typedef struct packed {
		logic        valid;
		logic        ok;
		logic [15:0] addr;
	} file_map_type;
endpackage

/* rtl/serial_port_link_controller.sv */
// Serial port link controller: framing, modem timing, command scheduler
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
module serial_port_link_controller
	import serial_link_pkg::*;
#(
	parameter int MS_CYCLES = CLK_HZ / 1000 * TICK_MS
)
(
	input  logic          clk,
	input  logic          reset_n,
	input  wb_req_type    wb_req,
	output wb_rsp_type    wb_rsp,
	input  tx_byte_type   tx_in,
	output logic          tx_take,
	output logic [15:0]   tx_check,
	output rx_byte_type   rx_out,
	output logic          txd,
	input  logic          rxd,
	output logic          rts,
	input  logic          cts,
	input  logic [7:0]    cmd_node,
	input  logic          cmd_reply_ok,
	input  logic          cmd_dle_ack,
	output cmd_issue_type cmd_out,
	output logic          enq_request,
	output db_write_type  db_out,
	input  file_req_type  file_req,
	output file_map_type  file_map
);
	typedef struct packed {
		wb_rsp_type       wb;
		logic [3:0]       dw;
		logic [1:0]       stops;
		logic [15:0]      hold_ms;
		logic [15:0]      lead_ms;
		logic [15:0]      trail_ms;
		logic             cts_en;
		logic [15:0]      gap_ms;
		logic [15:0]      cmd_total;
		logic [15:0]      space_ms;
		logic [15:0]      fault_ptr;
		logic [15:0]      wait_ms;
		logic [15:0]      resend_lim;
		logic [15:0]      skip_polls;
		logic [15:0]      health_ptr;
		logic [2:0]       parity;
		logic             role;
		logic             crc_sel;
		logic             run;
		logic [15:0]      bit_cyc;
		logic [16:0]      tick_cnt;
		logic             tick;
		tx_state_type     tx;
		logic [15:0]      tx_ms;
		logic [15:0]      tx_div;
		logic [11:0]      tx_frame;
		logic [3:0]       tx_left;
		logic             tx_last;
		logic             tx_first;
		logic             txd;
		logic             rts;
		logic             tx_take;
		logic [7:0]       bcc;
		logic [15:0]      crc;
		logic [15:0]      tx_check;
		logic             rx_busy;
		logic [15:0]      rx_div;
		logic [3:0]       rx_idx;
		logic [10:0]      rx_bits;
		rx_byte_type      rx;
		master_state_type m;
		logic [6:0]       cmd_idx;
		logic [3:0]       retries;
		logic [15:0]      cmd_ms;
		logic [15:0]      rsp_ms;
		logic [15:0]      gap_cnt;
		logic             gap_wait;
		cmd_issue_type    cmd;
		logic             enq_req;
		logic [7:0]       sweep;
		db_write_type     db;
		file_map_type     fmap;
	} link_state_type;

	link_state_type s;
	link_state_type next_s;
	logic [15:0]    skip_mem [0:255];
	logic           mem_we;
	logic [7:0]     mem_addr;
	logic [15:0]    mem_data;
	logic [15:0]    skip_rd;
	logic [15:0]    sweep_rd;

	function automatic logic [15:0] word_index(input logic [15:0] adr);
		word_index = {2'b00, adr[15:2]};
	endfunction

	function automatic logic [15:0] sat_inc(input logic [15:0] v,
		input logic t);
		sat_inc = (t && v != 16'hffff) ? 16'(v + 16'h0001) : v;
	endfunction

	function automatic logic parity_of(input logic [7:0] d,
		input logic [3:0] w, input logic [2:0] p);
		logic [7:0] m;
		m = d & ~(8'hff << w);
		case (p)
			PAR_ODD:  parity_of = ~^m;
			PAR_EVEN: parity_of = ^m;
			PAR_MARK: parity_of = 1'b1;
			default:  parity_of = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		crc_step = r;
	endfunction

	assign skip_rd  = skip_mem[cmd_node];
	assign sweep_rd = skip_mem[s.sweep];

	always_comb
	begin
		logic [15:0] v;
		logic [15:0] rd;
		logic [10:0] bits;
		logic        advance;
		logic        par_on;
		v = 16'h0000;
		rd = 16'h0000;
		bits = 11'h000;
		advance = 1'b0;
		par_on = s.parity != PAR_NONE;
		next_s = s;
		next_s.tx_take = 1'b0;
		next_s.rx.valid = 1'b0;
		next_s.cmd.issue = 1'b0;
		next_s.enq_req = 1'b0;
		next_s.db.wr = 1'b0;
		mem_we = 1'b0;
		mem_addr = s.sweep;
		mem_data = 16'h0000;

		// Register bus, one wait state, unmapped words read zero
		next_s.wb.ack = wb_req.cyc & wb_req.stb & ~s.wb.ack;
		if (next_s.wb.ack && wb_req.we)
		begin
			v[7:0]  = wb_req.sel[0] ? wb_req.dat[7:0] : 8'h00;
			v[15:8] = wb_req.sel[1] ? wb_req.dat[15:8] : 8'h00;
			case (word_index(wb_req.adr))
				IDX_DATA_WIDTH:
					if (v >= 16'(WIDTH_MIN) && v <= 16'(WIDTH_MAX))
						next_s.dw = v[3:0]; // RL1
				IDX_STOP_COUNT:
					if (v == 16'h0001 || v == 16'h0002)
						next_s.stops = v[1:0]; // RL2
				IDX_REPLY_HOLD:  next_s.hold_ms = v;
				IDX_RTS_LEAD:    next_s.lead_ms = v;
				IDX_RTS_TRAIL:   next_s.trail_ms = v;
				IDX_CTS_GATE:    if (v <= 16'h0001) next_s.cts_en = v[0];
				IDX_POLL_GAP:    next_s.gap_ms = v;
				IDX_CMD_TOTAL:
					if (v <= CMD_TOTAL_MAX) next_s.cmd_total = v; // RL8
				IDX_CMD_SPACING: next_s.space_ms = v;
				IDX_FAULT_DEST:
					if (v <= FAULT_DEST_MAX || v == PTR_NONE)
						next_s.fault_ptr = v; // RL10
				IDX_REPLY_WAIT:  next_s.wait_ms = v;
				IDX_RESEND_LIM:
					if (v <= RESEND_MAX) next_s.resend_lim = v; // RL12
				IDX_SKIP_POLLS:  next_s.skip_polls = v;
				IDX_HEALTH_DEST:
					if (v <= HEALTH_DEST_MAX || v == PTR_NONE)
						next_s.health_ptr = v; // RL14
				IDX_PARITY:      if (v <= 16'(PAR_SPACE)) next_s.parity = v[2:0];
				IDX_ROLE:        if (v <= 16'h0001) next_s.role = v[0];
				IDX_CHECK_MODE:  if (v <= 16'h0001) next_s.crc_sel = v[0];
				IDX_BIT_CYCLES:
					if (v >= BIT_CYCLES_MIN) next_s.bit_cyc = v;
				IDX_CONTROL:     next_s.run = v[0];
				default:         next_s.run = s.run;
			endcase
		end
		case (word_index(wb_req.adr))
			IDX_DATA_WIDTH:  rd = {12'h000, s.dw};
			IDX_STOP_COUNT:  rd = {14'h0000, s.stops};
			IDX_REPLY_HOLD:  rd = s.hold_ms;
			IDX_RTS_LEAD:    rd = s.lead_ms;
			IDX_RTS_TRAIL:   rd = s.trail_ms;
			IDX_CTS_GATE:    rd = {15'h0000, s.cts_en};
			IDX_POLL_GAP:    rd = s.gap_ms;
			IDX_CMD_TOTAL:   rd = s.cmd_total;
			IDX_CMD_SPACING: rd = s.space_ms;
			IDX_FAULT_DEST:  rd = s.fault_ptr;
			IDX_REPLY_WAIT:  rd = s.wait_ms;
			IDX_RESEND_LIM:  rd = s.resend_lim;
			IDX_SKIP_POLLS:  rd = s.skip_polls;
			IDX_HEALTH_DEST: rd = s.health_ptr;
			IDX_FILE_NUMBER: rd = FILE_FIRST; // RL15
			IDX_FILE_LENGTH: rd = FILE_WORDS; // RL16
			IDX_FILE_BASE:   rd = FILE_DB_BASE; // RL17
			IDX_PARITY:      rd = {13'h0000, s.parity};
			IDX_ROLE:        rd = {15'h0000, s.role};
			IDX_CHECK_MODE:  rd = {15'h0000, s.crc_sel};
			IDX_BIT_CYCLES:  rd = s.bit_cyc;
			IDX_CONTROL:     rd = {15'h0000, s.run};
			IDX_STATUS:      rd = {1'b0, s.cmd_idx, s.retries, s.rts,
				s.tx != TX_IDLE, s.rx_busy, s.gap_wait};
			default:         rd = 16'h0000;
		endcase
		if (next_s.wb.ack)
			next_s.wb.dat = {16'h0000, rd};

		// Shared millisecond tick
		next_s.tick = s.tick_cnt == 17'(MS_CYCLES - 1); // RL21
		next_s.tick_cnt = next_s.tick ? 17'h00000 : 17'(s.tick_cnt + 1);

		// Transmitter and modem control
		next_s.tx_ms = sat_inc(s.tx_ms, s.tick); // RL21
		case (s.tx)
			TX_IDLE:
				if (tx_in.valid && s.run)
				begin
					next_s.tx = TX_HOLD;
					next_s.tx_ms = 16'h0000;
					next_s.tx_first = 1'b1;
				end
			TX_HOLD:
				// Only a slave's answers are held back
				if (s.role == ROLE_SLAVE && s.rx_busy)
					next_s.tx_ms = 16'h0000;
				else if (s.role == ROLE_MASTER || s.tx_ms >= s.hold_ms)
				begin
					next_s.tx = TX_LEAD; // RL3 RL19
					next_s.rts = 1'b1;
					next_s.tx_ms = 16'h0000;
				end
			TX_LEAD:
				if (s.tx_ms >= s.lead_ms)
					next_s.tx = TX_CTS; // RL4
			TX_CTS:
				if (tx_in.valid && (!s.cts_en || cts)) // RL6
				begin
					next_s.tx_take = 1'b1;
					next_s.tx_last = tx_in.last;
					next_s.tx_div = 16'h0000;
					next_s.tx_first = 1'b0;
					next_s.tx_frame = 12'hfff;
					next_s.tx_frame[0] = 1'b0;
					for (int i = 0; i < 8; i++)
						if (i < s.dw)
							next_s.tx_frame[i + 1] = tx_in.data[i]; // RL1
					if (par_on)
						next_s.tx_frame[s.dw + 1] =
							parity_of(tx_in.data, s.dw, s.parity); // RL18
					next_s.tx_left = 4'(s.dw + par_on + s.stops + 1); // RL2
					next_s.bcc = 8'(s.tx_first ? 8'h00 : s.bcc) + tx_in.data;
					next_s.crc = crc_step(s.tx_first ? 16'h0000 : s.crc,
						tx_in.data);
					next_s.tx = TX_SHIFT;
				end
			TX_SHIFT:
			begin
				next_s.tx_div = 16'(s.tx_div + 1);
				if (s.tx_div >= 16'(s.bit_cyc - 1))
				begin
					next_s.tx_div = 16'h0000;
					next_s.tx_frame = {1'b1, s.tx_frame[11:1]};
					next_s.tx_left = 4'(s.tx_left - 1);
					if (s.tx_left == 4'h1)
					begin
						next_s.tx = s.tx_last ? TX_TRAIL : TX_CTS;
						next_s.tx_ms = 16'h0000;
					end
				end
			end
			TX_TRAIL:
				if (s.tx_ms >= s.trail_ms)
				begin
					next_s.tx = TX_IDLE; // RL5
					next_s.rts = 1'b0;
				end
			default: next_s.tx = TX_IDLE;
		endcase
		next_s.txd = next_s.tx == TX_SHIFT ? next_s.tx_frame[0] : 1'b1;
		// Check field tracks the bytes of the current message
		next_s.tx_check = s.crc_sel == CHECK_CRC ? next_s.crc
			: {8'h00, 8'(8'h00 - next_s.bcc)}; // RL20

		// Receiver, mid-bit sampling
		if (!s.rx_busy)
		begin
			if (!rxd)
			begin
				next_s.rx_busy = 1'b1;
				next_s.rx_div = {1'b0, s.bit_cyc[15:1]};
				next_s.rx_idx = 4'h0;
			end
		end
		else
		begin
			next_s.rx_div = 16'(s.rx_div + 1);
			if (s.rx_div >= 16'(s.bit_cyc - 1))
			begin
				next_s.rx_div = 16'h0000;
				bits = s.rx_bits;
				bits[s.rx_idx] = rxd;
				next_s.rx_bits = bits;
				next_s.rx_idx = 4'(s.rx_idx + 1);
				if (s.rx_idx == 4'(s.dw + par_on + 1))
				begin
					next_s.rx_busy = 1'b0;
					next_s.rx.valid = 1'b1;
					for (int i = 0; i < 8; i++)
						next_s.rx.data[i] = i < s.dw ? bits[i + 1] : 1'b0;
					next_s.rx.parity_err = par_on && bits[s.dw + 1] !=
						parity_of(next_s.rx.data, s.dw, s.parity); // RL18
					next_s.rx.frame_err = bits[0] ||
						!bits[s.dw + par_on + 1];
				end
			end
		end

		// Master command scheduler
		next_s.cmd_ms = sat_inc(s.cmd_ms, s.tick);
		next_s.rsp_ms = sat_inc(s.rsp_ms, s.tick);
		next_s.gap_cnt = sat_inc(s.gap_cnt, s.tick);
		case (s.m)
			M_CLEAR:
			begin
				// Skip counters have no reset, so they are swept clear
				mem_we = 1'b1;
				next_s.sweep = 8'(s.sweep + 1);
				if (s.sweep == 8'hff)
					next_s.m = M_IDLE;
			end
			M_IDLE:
				if (s.run && s.role == ROLE_MASTER && s.cmd_total != 0)
				begin
					next_s.cmd_idx = 7'h00;
					next_s.m = M_SPACE;
				end
			M_SPACE:
				if (!s.run || s.role != ROLE_MASTER || s.cmd_total == 0)
					next_s.m = M_IDLE;
				else if (16'(s.cmd_idx) >= s.cmd_total)
					next_s.cmd_idx = 7'h00; // RL8
				else if (s.cmd_ms >= s.space_ms)
					next_s.m = M_PICK; // RL9
			M_PICK:
			begin
				mem_addr = cmd_node;
				if (skip_rd != 16'h0000)
				begin
					mem_we = 1'b1;
					mem_data = 16'(skip_rd - 1); // RL13
					advance = 1'b1;
				end
				else
				begin
					next_s.cmd = '{issue: 1'b1, retry: 1'b0,
						index: s.cmd_idx};
					next_s.retries = 4'h0;
					next_s.cmd_ms = 16'h0000;
					next_s.rsp_ms = 16'h0000;
					next_s.gap_wait = 1'b0;
					next_s.m = M_WAIT;
				end
			end
			M_WAIT:
			begin
				if (cmd_dle_ack)
				begin
					next_s.gap_wait = 1'b1;
					next_s.gap_cnt = 16'h0000;
				end
				else if (s.gap_wait && s.gap_cnt >= s.gap_ms)
				begin
					next_s.gap_wait = 1'b0; // RL7
					next_s.enq_req = 1'b1;
				end
				if (cmd_reply_ok)
					advance = 1'b1;
				else if (s.rsp_ms >= s.wait_ms) // RL11
				begin
					next_s.gap_wait = 1'b0;
					if (16'(s.retries) < s.resend_lim)
					begin
						next_s.retries = 4'(s.retries + 1); // RL12
						next_s.cmd = '{issue: 1'b1, retry: 1'b1,
							index: s.cmd_idx}; // RL9
						next_s.rsp_ms = 16'h0000;
					end
					else
					begin
						mem_we = 1'b1;
						mem_addr = cmd_node;
						mem_data = s.skip_polls; // RL13
						next_s.db = '{wr: s.fault_ptr != PTR_NONE,
							addr: s.fault_ptr,
							data: {9'h000, s.cmd_idx}}; // RL10
						advance = 1'b1;
					end
				end
			end
			M_SWEEP:
			begin
				next_s.db = '{wr: 1'b1,
					addr: 16'(s.health_ptr + s.sweep),
					data: {15'h0000, sweep_rd != 16'h0000}}; // RL14
				next_s.sweep = 8'(s.sweep + 1);
				if (s.sweep == 8'hff)
					next_s.m = M_SPACE;
			end
			default: next_s.m = M_IDLE;
		endcase
		if (advance)
		begin
			next_s.m = M_SPACE;
			next_s.cmd_idx = 7'(s.cmd_idx + 1);
			if (16'(s.cmd_idx + 1) >= s.cmd_total)
			begin
				next_s.cmd_idx = 7'h00; // RL8
				next_s.sweep = 8'h00;
				if (s.health_ptr != PTR_NONE)
					next_s.m = M_SWEEP; // RL14
			end
		end

		// Simulated integer file addressing
		next_s.fmap.valid = file_req.valid;
		if (file_req.valid)
		begin
			next_s.fmap.ok = file_req.number >= FILE_FIRST &&
				file_req.element < FILE_WORDS; // RL15 RL16
			next_s.fmap.addr = 16'(FILE_DB_BASE + file_req.element +
				16'(file_req.number - FILE_FIRST) * FILE_WORDS); // RL17
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '0;
			s.dw <= WIDTH_MAX;
			s.stops <= 2'h1;
			s.fault_ptr <= PTR_NONE;
			s.health_ptr <= PTR_NONE;
			s.bit_cyc <= BIT_CYCLES_RST;
			s.tx <= TX_IDLE;
			s.m <= M_CLEAR;
			s.txd <= 1'b1;
			s.tx_first <= 1'b1;
		end
		else
			s <= next_s;
	end

	// Skip counter store: plain array, no reset, cleared after reset
	always_ff @(posedge clk)
	begin
		if (mem_we)
			skip_mem[mem_addr] <= mem_data;
	end

	assign wb_rsp      = s.wb;
	assign tx_take     = s.tx_take;
	assign tx_check    = s.tx_check;
	assign rx_out      = s.rx;
	assign txd         = s.txd;
	assign rts         = s.rts;
	assign cmd_out     = s.cmd;
	assign enq_request = s.enq_req;
	assign db_out      = s.db;
	assign file_map    = s.fmap;
endmodule

/* tb/serial_link_checker.sv */
// Port checker for the serial link controller, bound to its top
`timescale 1ns/100ps
module serial_link_checker
	import serial_link_pkg::*;
(
	input logic          clk,
	input logic          reset_n,
	input wb_req_type    wb_req,
	input wb_rsp_type    wb_rsp,
	input logic          tx_take,
	input logic          txd,
	input logic          rts,
	input cmd_issue_type cmd_out,
	input file_req_type  file_req,
	input file_map_type  file_map
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	logic [6:0] last_index;

	// Index of the latest issue, for retry comparison
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			last_index <= 7'h00;
		else if (cmd_out.issue)
			last_index <= cmd_out.index;
	end

	property p_ack_wait;
		wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("ack late");
	property p_ack_once;
		wb_rsp.ack |=> !wb_rsp.ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_map_ok;
		file_req.valid && file_req.number >= FILE_FIRST
			&& file_req.element < FILE_WORDS |=> file_map.valid
			&& file_map.ok && file_map.addr == ($past(file_req.number)
			- FILE_FIRST) * FILE_WORDS + $past(file_req.element);
	endproperty
	a_map_ok: assert property (p_map_ok) else $error("bad map");
	property p_map_bad;
		file_req.valid && (file_req.number < FILE_FIRST
			|| file_req.element >= FILE_WORDS) |=> !file_map.ok;
	endproperty
	a_map_bad: assert property (p_map_bad) else $error("map ok");
	property p_map_idle;
		!file_req.valid |=> !file_map.valid;
	endproperty
	a_map_idle: assert property (p_map_idle) else $error("map");
	property p_quiet_line;
		!rts |-> txd;
	endproperty
	a_quiet_line: assert property (p_quiet_line) else $error("txd");
	property p_take_rts;
		tx_take |-> rts;
	endproperty
	a_take_rts: assert property (p_take_rts) else $error("no rts");
	property p_start_bit;
		tx_take |-> ##[0:2] !txd;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start");
	property p_retry_same;
		cmd_out.issue && cmd_out.retry |-> cmd_out.index == last_index;
	endproperty
	a_retry_same: assert property (p_retry_same) else $error("rt");
endmodule

bind serial_port_link_controller serial_link_checker u_serial_link_checker
	(.clk, .reset_n, .wb_req, .wb_rsp, .tx_take, .txd, .rts, .cmd_out,
	.file_req, .file_map);

/* tb/serial_far_station.sv */
// Far station model: modem answering RTS with CTS, idle receive line
`timescale 1ns/100ps
module serial_far_station
(
	input  logic       clk,
	input  logic       reset_n,
	input  logic       rts,
	input  logic       stall,
	input  logic [3:0] lag,
	output logic       cts,
	output logic       rxd
);
	logic [3:0] age;

	// Nothing is sent back, so the line rests at mark
	assign rxd = 1'b1;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			age <= 4'h0;
			cts <= 1'b0;
		end
		else
		begin
			age <= rts ? ((age == 4'hf) ? age : age + 4'h1) : 4'h0;
			cts <= rts && !stall && age >= lag;
		end
	end
endmodule

/* tb/tb.sv */
// Self-checking bench for the serial link controller
`timescale 1ns/100ps
module tb;
	import serial_link_pkg::*;
	localparam int MS = 10;
	logic          clk;
	logic          reset_n;
	wb_req_type    wb_req;
	wb_rsp_type    wb_rsp;
	tx_byte_type   tx_in;
	logic          tx_take;
	logic [15:0]   tx_check;
	logic          enq_request;
	logic          txd;
	logic          rxd;
	logic          rts;
	logic          cts;
	logic          stall;
	logic [3:0]    lag;
	logic [7:0]    cmd_node;
	logic          cmd_reply_ok;
	logic          cmd_dle_ack;
	cmd_issue_type cmd_out;
	db_write_type  db_out;
	file_req_type  file_req;
	file_map_type  file_map;
	int            failures;
	int            checks_done;

	serial_port_link_controller #(.MS_CYCLES(MS)) u_serial_port_link_controller
		(.clk, .reset_n, .wb_req, .wb_rsp, .tx_in, .tx_take, .tx_check,
		.rx_out(), .txd, .rxd, .rts, .cts, .cmd_node, .cmd_reply_ok,
		.cmd_dle_ack, .cmd_out, .enq_request, .db_out, .file_req,
		.file_map);
	serial_far_station u_serial_far_station
		(.clk, .reset_n, .rts, .stall, .lag, .cts, .rxd);

	always #5 clk = ~clk;

	task automatic report_and_stop();
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic tmo(input int n, input int lim);
		if (n >= lim)
		begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic bus(input logic [15:0] i, input logic w,
		input logic [15:0] d, output logic [31:0] q);
		int n;
		wb_req <= {1'b1, 1'b1, w, i[13:0], 2'b00, 4'h3, 16'h0000, d};
		for (n = 0; n < 20 && wb_rsp.ack !== 1'b1; n++)
			@(posedge clk);
		tmo(n, 20);
		q = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [15:0] i, input logic [15:0] d);
		logic [31:0] q;
		bus(i, 1'b1, d, q);
	endtask

	task automatic rd(input logic [15:0] i, input logic [15:0] e);
		logic [31:0] q;
		bus(i, 1'b0, 16'h0000, q);
		check(q, {16'h0000, e});
	endtask

	task automatic wr_rd(input logic [15:0] i, input logic [15:0] w,
		input logic [15:0] e);
		wr(i, w);
		rd(i, e);
	endtask

	function automatic logic [11:0] frm(input int dw, input int par,
		input logic [7:0] d);
		logic [11:0] f;
		logic [7:0]  m;
		m = d & 8'((1 << dw) - 1);
		f = 12'hfff;
		f[0] = 1'b0;
		for (int i = 0; i < dw; i++)
			f[i + 1] = m[i];
		if (par != 0)
			f[dw + 1] = (par == 1) ? ~^m : (par == 2) ? ^m : (par == 3);
		return f;
	endfunction

	// Two-byte message; the wire is recorded and judged afterwards
	task automatic t_frame(input int dw, input int st, input int par,
		input logic [7:0] d);
		logic        qt[$];
		logic        qr[$];
		logic [11:0] x;
		int          n;
		int          k;
		int          a;
		int          b;
		int          fl;
		wr(IDX_DATA_WIDTH, 16'(dw));
		wr(IDX_STOP_COUNT, 16'(st));
		wr(IDX_PARITY, 16'(par));
		tx_in <= {1'b1, 1'b0, d};
		k = 0;
		for (n = 0; n < 2000; n++)
		begin
			@(posedge clk);
			qt.push_back(txd);
			qr.push_back(rts);
			if (tx_take === 1'b1)
			begin
				k++;
				tx_in <= (k == 1) ? {1'b1, 1'b1, ~d} : '0;
			end
			if (k == 2 && rts === 1'b0)
				break;
		end
		tmo(n, 2000);
		for (a = 0; a < n && qr[a] !== 1'b1; a++);
		for (b = a; b < n && qt[b] !== 1'b0; b++);
		fl = 1 + dw + 32'(par != 0) + st;
		x = frm(dw, par, d);
		for (k = 0; k < fl; k++)
			check(32'(qt[b + 4 + 8 * k]), 32'(x[k]));
		check(32'(qt[b + 8 * fl + 1]), 32'h0);
		check(32'(b - a >= MS && b - a <= 2 * MS + 4), 32'h1);
		k = qr.size() - 1 - b - 16 * fl;
		check(32'(k >= MS && k <= 2 * MS + 4), 32'h1);
		check(32'(tx_check), 32'h1);
	endtask

	task automatic t_cts(input logic [15:0] gate);
		int n;
		wr(IDX_CTS_GATE, gate);
		stall <= 1'b1;
		tx_in <= {1'b1, 1'b1, 8'h81};
		for (n = 0; n < 100 && tx_take !== 1'b1; n++)
			@(posedge clk);
		check(32'(n == 100), {31'h0, gate[0]});
		stall <= 1'b0;
		for (n = 0; n < 100 && tx_take !== 1'b1; n++)
			@(posedge clk);
		tx_in <= '0;
		tmo(n, 100);
		for (n = 0; n < 2000 && rts !== 1'b0; n++)
			@(posedge clk);
		tmo(n, 2000);
	endtask

	task automatic fmap(input logic [15:0] num, input logic [15:0] el,
		input logic ok, input logic [15:0] ad);
		file_req <= {1'b1, num, el};
		@(posedge clk);
		file_req <= '0;
		@(posedge clk);
		check(32'({file_map.valid, file_map.ok}), 32'({1'b1, ok}));
		if (ok)
			check(32'(file_map.addr), 32'(ad));
	endtask

	task automatic t_sched();
		int n;
		int iss;
		int rty;
		int enq;
		wr(IDX_REPLY_WAIT, 16'h0001);
		wr(IDX_RESEND_LIM, 16'h0002);
		wr(IDX_FAULT_DEST, 16'h0010);
		wr(IDX_CMD_TOTAL, 16'h0001);
		iss = 0;
		rty = 0;
		enq = 0;
		for (n = 0; n < 500 && db_out.wr !== 1'b1; n++)
		begin
			@(posedge clk);
			if (cmd_out.issue === 1'b1)
			begin
				iss++;
				rty += 32'(cmd_out.retry);
				check(32'(cmd_out.index), 32'h0);
			end
			enq += 32'(enq_request === 1'b1);
			cmd_dle_ack <= iss == 1;
		end
		tmo(n, 500);
		check(32'(iss), 32'h3);
		check(32'(rty), 32'h2);
		check(32'(enq), 32'h1);
		check({db_out.addr, db_out.data}, 32'h00100000);
		wr(IDX_CMD_TOTAL, 16'h0000);
	endtask

	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		wb_req = '0;
		tx_in = '0;
		stall = 1'b0;
		lag = 4'h6;
		cmd_node = 8'h00;
		cmd_reply_ok = 1'b0;
		cmd_dle_ack = 1'b0;
		file_req = '0;
		failures = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(IDX_DATA_WIDTH, 16'h0008);
		rd(IDX_STOP_COUNT, 16'h0001);
		rd(IDX_HEALTH_DEST, PTR_NONE);
		rd(IDX_FILE_LENGTH, FILE_WORDS);
		rd(IDX_FILE_BASE, FILE_DB_BASE);
		rd(16'h13a7, 16'h0000);
		rd(16'h0100, 16'h0000);
		wr_rd(IDX_DATA_WIDTH, 16'h0004, 16'h0008);
		wr_rd(IDX_DATA_WIDTH, 16'h0009, 16'h0008);
		wr_rd(IDX_STOP_COUNT, 16'h0003, 16'h0001);
		wr_rd(IDX_CMD_TOTAL, 16'h0065, 16'h0000);
		wr_rd(IDX_RESEND_LIM, 16'h000b, 16'h0000);
		wr_rd(IDX_FAULT_DEST, 16'h1388, PTR_NONE);
		wr_rd(IDX_HEALTH_DEST, 16'h1288, PTR_NONE);
		wr_rd(IDX_HEALTH_DEST, 16'h1287, 16'h1287);
		wr_rd(IDX_PARITY, 16'h0005, 16'h0000);
		wr_rd(IDX_FILE_NUMBER, 16'h0009, FILE_FIRST);
		wr_rd(IDX_ROLE, 16'(ROLE_MASTER), 16'h0000);
		wr(IDX_HEALTH_DEST, PTR_NONE);
		wr(IDX_BIT_CYCLES, 16'h0008);
		wr(IDX_RTS_LEAD, 16'h0002);
		wr(IDX_RTS_TRAIL, 16'h0002);
		wr(IDX_CONTROL, 16'h0001);
		t_frame(8, 1, 0, 8'ha5);
		t_frame(7, 2, 1, 8'h3c);
		t_frame(6, 1, 2, 8'h5a);
		t_frame(5, 2, 3, 8'h13);
		t_frame(8, 2, 4, 8'hc6);
		t_cts(16'h0001);
		t_cts(16'h0000);
		fmap(16'h0007, 16'h0000, 1'b1, 16'h0000);
		fmap(16'h0008, 16'h0005, 1'b1, 16'h00cd);
		fmap(16'h0009, 16'h00c7, 1'b1, 16'h0257);
		fmap(16'h0007, 16'h00c8, 1'b0, 16'h0000);
		fmap(16'h0006, 16'h0000, 1'b0, 16'h0000);
		t_sched();
		report_and_stop();
	end
endmodule
